/* design/imudt_regs.sv */
`timescale 1ns/1ps
module imudt_regs
	import imudt_pkg::*;
(
	// clock and reset
	input  wire logic                clk_sys,
	input  wire logic                reset,
	// serial host pins
	input  wire logic                spi_cs_n,
	input  wire logic                spi_sclk,
	input  wire logic                spi_din,
	output logic                     spi_dout,
	// self-test results, held levels
	input  wire logic [FLAG_W-1:0]   selftest_fail,
	// sample stream
	input  wire logic                sample_valid,
	input  wire logic [WORD_W-1:0]   temp_sample,
	input  wire logic [RATE_W-1:0]   rate_x_sample,
	input  wire logic [RATE_W-1:0]   rate_y_sample,
	input  wire logic [RATE_W-1:0]   rate_z_sample,
	// status
	output logic                     sensor_fail,
	output logic [WORD_W-1:0]        page_select
);
	imudt_frame_if fr ();

	logic              cmd_write;
	logic [ADDR_W-1:0] cmd_addr;
	logic [BYTE_W-1:0] cmd_data;
	logic              on_page0;
	logic              rd_frame;
	logic              wr_frame;
	logic              flags_rd_clr;
	logic              sys_rd_clr;
	logic [FLAG_W-1:0] flags_reg;
	logic [FLAG_W-1:0] flags_next;
	logic              sys_fail_reg;
	logic              sys_fail_next;
	logic [WORD_W-1:0] page_reg;
	logic [WORD_W-1:0] temp_reg;
	logic [RATE_W-1:0] rate_in  [AXES];
	logic [RATE_W-1:0] rate_reg [AXES];
	logic [WORD_W-1:0] reply_reg;
	logic [WORD_W-1:0] reply_next;

	imudt_spi_engine u_engine (
		.clk_sys  (clk_sys),
		.reset    (reset),
		.spi_cs_n (spi_cs_n),
		.spi_sclk (spi_sclk),
		.spi_din  (spi_din),
		.spi_dout (spi_dout),
		.fr       (fr.engine)
	);

	assign cmd_write = fr.frame_word[CMD_WR_BIT];
	assign cmd_addr  = fr.frame_word[ADDR_MSB:ADDR_LSB];
	assign cmd_data  = fr.frame_word[BYTE_W-1:0];
	assign on_page0  = page_reg == PAGE_ZERO;
	assign rd_frame  = fr.frame_valid & ~cmd_write;
	assign wr_frame  = fr.frame_valid & cmd_write;

	assign flags_rd_clr = rd_frame & on_page0
		& word_hit(cmd_addr, ADDR_FLAGS);
	assign sys_rd_clr   = rd_frame & on_page0
		& word_hit(cmd_addr, ADDR_SYSERR);

	// set wins over clear: a failure still present survives the read
	always_comb
	begin
		flags_next = flags_reg;
		if (flags_rd_clr)
			flags_next = FLAGS_RST;
		flags_next = flags_next | selftest_fail;
	end

	always_comb
	begin
		sys_fail_next = sys_fail_reg & ~sys_rd_clr;
		sys_fail_next = sys_fail_next | (|selftest_fail);
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			flags_reg <= FLAGS_RST;
		else
			flags_reg <= flags_next;
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			sys_fail_reg <= 1'b0;
		else
			sys_fail_reg <= sys_fail_next;
	end

	assign sensor_fail = sys_fail_reg;

	// page register answers on every page; byte lane from address bit 0
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			page_reg <= PAGE_RST;
		else if (wr_frame && word_hit(cmd_addr, ADDR_PAGE))
		begin
			if (cmd_addr[0])
				page_reg[WORD_W-1:BYTE_W] <= cmd_data;
			else
				page_reg[BYTE_W-1:0] <= cmd_data;
		end
	end

	assign page_select = page_reg;

	// measurement words move only on a sample, never on a host write
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			temp_reg <= DATA_RST;
		else if (sample_valid)
			temp_reg <= temp_sample;
	end

	assign rate_in[0] = rate_x_sample;
	assign rate_in[1] = rate_y_sample;
	assign rate_in[2] = rate_z_sample;

	// both halves live in one flop word, so a sample never tears
	generate
		for (genvar g = 0; g < AXES; g++)
		begin : g_axis
			always_ff @(posedge clk_sys or posedge reset)
			begin
				if (reset)
					rate_reg[g] <= RATE_RST;
				else if (sample_valid)
					rate_reg[g] <= rate_in[g];
			end
		end
	endgenerate

	always_comb
	begin
		reply_next = DATA_RST;
		if (word_hit(cmd_addr, ADDR_PAGE))
			reply_next = page_reg;
		if (on_page0)
		begin
			if (word_hit(cmd_addr, ADDR_FLAGS))
				reply_next = {{(WORD_W-FLAG_W){1'b0}}, flags_reg};
			if (word_hit(cmd_addr, ADDR_SYSERR))
				reply_next = WORD_W'(sys_fail_reg) << SYS_SENSOR_BIT;
			if (word_hit(cmd_addr, ADDR_TEMP))
				reply_next = temp_reg;
			for (int i = 0; i < AXES; i++)
			begin
				if (word_hit(cmd_addr, ADDR_RATE_HI[i]))
					reply_next = rate_reg[i][RATE_W-1:WORD_W];
				if (word_hit(cmd_addr, ADDR_RATE_LO[i]))
					reply_next = rate_reg[i][WORD_W-1:0];
			end
		end
		if (cmd_write)
			reply_next = DATA_RST;
	end

	// reply stands until the next frame and goes out during that frame
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			reply_reg <= DATA_RST;
		else if (fr.frame_valid)
			reply_reg <= reply_next;
	end

	assign fr.reply_word = reply_reg;

	property p_flags_set;
		@(posedge clk_sys) disable iff (reset)
		(|selftest_fail) |=>
			((flags_reg & $past(selftest_fail)) == $past(selftest_fail));
	endproperty
	a_flags_set: assert property (p_flags_set)
		else $error("failing sensor did not raise its flag");

	property p_upper_zero;
		@(posedge clk_sys) disable iff (reset)
		flags_rd_clr |=> (reply_reg[WORD_W-1:FLAG_W] == '0);
	endproperty
	a_upper_zero: assert property (p_upper_zero)
		else $error("unused flag bits read nonzero");

	property p_sys_fail;
		@(posedge clk_sys) disable iff (reset)
		(|selftest_fail) |=> sensor_fail;
	endproperty
	a_sys_fail: assert property (p_sys_fail)
		else $error("overall self-test failure not reported");

	property p_read_value;
		@(posedge clk_sys) disable iff (reset)
		flags_rd_clr |=>
			(reply_reg[FLAG_W-1:0] == $past(flags_reg));
	endproperty
	a_read_value: assert property (p_read_value)
		else $error("flag read returned wrong value");

	sequence s_clear_read;
		flags_rd_clr && selftest_fail == '0;
	endsequence
	property p_read_clears;
		@(posedge clk_sys) disable iff (reset)
		s_clear_read |=> (flags_reg == FLAGS_RST);
	endproperty
	a_read_clears: assert property (p_read_clears)
		else $error("flag read did not clear flags");

	property p_flag_persists;
		@(posedge clk_sys) disable iff (reset)
		(flags_rd_clr && (|selftest_fail)) |=>
			(flags_reg == $past(selftest_fail));
	endproperty
	a_flag_persists: assert property (p_flag_persists)
		else $error("persisting failure lost after read");

	property p_temp_load;
		@(posedge clk_sys) disable iff (reset)
		sample_valid |=> (temp_reg == $past(temp_sample));
	endproperty
	a_temp_load: assert property (p_temp_load)
		else $error("temperature word not loaded from sample");

	property p_rate_coherent;
		@(posedge clk_sys) disable iff (reset)
		sample_valid |=> (rate_reg[0] == $past(rate_x_sample))
			&& (rate_reg[2] == $past(rate_z_sample));
	endproperty
	a_rate_coherent: assert property (p_rate_coherent)
		else $error("rate words not loaded together");

	property p_rate_high;
		@(posedge clk_sys) disable iff (reset)
		(rd_frame && on_page0 && word_hit(cmd_addr, ADDR_RATE_HI[1]))
			|=> (reply_reg == $past(rate_reg[1][RATE_W-1:WORD_W]));
	endproperty
	a_rate_high: assert property (p_rate_high)
		else $error("high rate word read wrong");

	property p_rate_low;
		@(posedge clk_sys) disable iff (reset)
		(rd_frame && on_page0 && word_hit(cmd_addr, ADDR_RATE_LO[1]))
			|=> (reply_reg == $past(rate_reg[1][WORD_W-1:0]));
	endproperty
	a_rate_low: assert property (p_rate_low)
		else $error("low rate word read wrong");

	property p_other_page;
		@(posedge clk_sys) disable iff (reset)
		(rd_frame && !on_page0 && !word_hit(cmd_addr, ADDR_PAGE))
			|=> (reply_reg == DATA_RST);
	endproperty
	a_other_page: assert property (p_other_page)
		else $error("page zero data visible on another page");

	property p_write_ignored;
		@(posedge clk_sys) disable iff (reset)
		(wr_frame && !sample_valid && selftest_fail == '0)
			|=> $stable(temp_reg) && $stable(rate_reg[0])
			&& (flags_reg == $past(flags_reg));
	endproperty
	a_write_ignored: assert property (p_write_ignored)
		else $error("host write changed block contents");

	property p_sys_read;
		@(posedge clk_sys) disable iff (reset)
		sys_rd_clr
			|=> (reply_reg[SYS_SENSOR_BIT] == $past(sys_fail_reg));
	endproperty
	a_sys_read: assert property (p_sys_read)
		else $error("system error read returned wrong bit");

	property p_sys_clear;
		@(posedge clk_sys) disable iff (reset)
		(sys_rd_clr && selftest_fail == '0) |=> !sensor_fail;
	endproperty
	a_sys_clear: assert property (p_sys_clear)
		else $error("system error bit not cleared by read");

	property p_temp_read;
		@(posedge clk_sys) disable iff (reset)
		(rd_frame && on_page0 && word_hit(cmd_addr, ADDR_TEMP))
			|=> (reply_reg == $past(temp_reg));
	endproperty
	a_temp_read: assert property (p_temp_read)
		else $error("temperature word read wrong");

	property p_rate_y_load;
		@(posedge clk_sys) disable iff (reset)
		sample_valid |=> (rate_reg[1] == $past(rate_y_sample));
	endproperty
	a_rate_y_load: assert property (p_rate_y_load)
		else $error("middle axis rate not loaded with the others");

	property p_write_reply;
		@(posedge clk_sys) disable iff (reset)
		wr_frame |=> (reply_reg == DATA_RST);
	endproperty
	a_write_reply: assert property (p_write_reply)
		else $error("write frame left a nonzero reply");

	property p_page_low;
		@(posedge clk_sys) disable iff (reset)
		(wr_frame && word_hit(cmd_addr, ADDR_PAGE) && !cmd_addr[0])
			|=> (page_reg[BYTE_W-1:0] == $past(cmd_data));
	endproperty
	a_page_low: assert property (p_page_low)
		else $error("page low byte not written");

	property p_page_high;
		@(posedge clk_sys) disable iff (reset)
		(wr_frame && word_hit(cmd_addr, ADDR_PAGE) && cmd_addr[0])
			|=> (page_reg[WORD_W-1:BYTE_W] == $past(cmd_data));
	endproperty
	a_page_high: assert property (p_page_high)
		else $error("page high byte not written");
endmodule : imudt_regs

/* design/imudt_pkg.sv */
// Overview of operation
// - set self-test flag bits 0, 1, 2 for failing x, y, z rate sensors
// - set flag bits 3, 4, 5 for failing x, y, z accelerometers; 1 is failure
// - flag register resets to 0x0000; bits 15 to 6 always read zero
// - system error bit 5 reports overall self-test result, 1 is failure
// - reading the flag register returns flags, then clears all its bits
// - a cleared flag sets again while its failure condition persists
// - temperature word is twos complement, 70 counts per degree, 0 at 25 C
// - each axis rate is 32-bit twos complement split in high and low words
// - high rate word covers +-100 deg/s at 0.005 deg/s per count
// - low rate word carries sixteen extra resolution bits below high word
// - host selects page through page register; this block lives on page 0
package imudt_pkg;
	localparam int WORD_W         = 16;
	localparam int BYTE_W         = 8;
	localparam int CNT_W          = 4;
	localparam int CMD_WR_BIT     = 15;
	localparam int ADDR_MSB       = 14;
	localparam int ADDR_LSB       = 8;
	localparam int ADDR_W         = 7;
	localparam int FLAG_W         = 6;
	localparam int AXES           = 3;
	localparam int RATE_W         = 32;
	localparam int SYS_SENSOR_BIT = 5;

	localparam logic [CNT_W-1:0]  FRAME_LAST  = 4'hF;
	localparam logic [ADDR_W-1:0] ADDR_PAGE   = 7'h00;
	localparam logic [ADDR_W-1:0] ADDR_SYSERR = 7'h08;
	localparam logic [ADDR_W-1:0] ADDR_FLAGS  = 7'h0A;
	localparam logic [ADDR_W-1:0] ADDR_TEMP   = 7'h0E;
	localparam logic [ADDR_W-1:0] ADDR_RATE_LO [AXES] =
		'{7'h10, 7'h14, 7'h18};
	localparam logic [ADDR_W-1:0] ADDR_RATE_HI [AXES] =
		'{7'h12, 7'h16, 7'h1A};

	localparam logic [WORD_W-1:0] PAGE_RST  = 16'h0000;
	localparam logic [WORD_W-1:0] PAGE_ZERO = 16'h0000;
	localparam logic [WORD_W-1:0] DATA_RST  = 16'h0000;
	localparam logic [FLAG_W-1:0] FLAGS_RST = 6'h00;
	localparam logic [RATE_W-1:0] RATE_RST  = 32'h00000000;

	typedef enum logic [1:0]
	{
		IMUDT_IDLE  = 2'b00,
		IMUDT_SHIFT = 2'b01,
		IMUDT_HOLD  = 2'b11
	} imudt_spi_state_t;

	// byte address to 16-bit word match
	function automatic logic word_hit(
		input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] base
	);
		return a[ADDR_W-1:1] == base[ADDR_W-1:1];
	endfunction : word_hit
endpackage : imudt_pkg

/* design/imudt_frame_if.sv */
`timescale 1ns/1ps
interface imudt_frame_if;
	import imudt_pkg::*;
	logic              frame_valid;
	logic [WORD_W-1:0] frame_word;
	logic [WORD_W-1:0] reply_word;

	modport engine (
		output frame_valid,
		output frame_word,
		input  reply_word
	);
	modport regs (
		input  frame_valid,
		input  frame_word,
		output reply_word
	);
endinterface : imudt_frame_if

/* design/imudt_spi_engine.sv */
`timescale 1ns/1ps
module imudt_spi_engine
	import imudt_pkg::*;
(
	// clock and reset
	input  wire logic     clk_sys,
	input  wire logic     reset,
	// serial pins
	input  wire logic     spi_cs_n,
	input  wire logic     spi_sclk,
	input  wire logic     spi_din,
	output logic          spi_dout,
	// frames to register file
	imudt_frame_if.engine fr
);
	localparam int PIN_CS   = 0;
	localparam int PIN_SCLK = 1;
	localparam int PIN_DIN  = 2;
	localparam logic [2:0] PIN_IDLE = 3'h3;

	logic [2:0]        pin_meta_reg;
	logic [2:0]        pin_sync_reg;
	logic              sclk_last_reg;
	logic              cs_n_s;
	logic              sclk_rise;
	logic              sclk_fall;
	imudt_spi_state_t  state_reg;
	logic [CNT_W-1:0]  cnt_reg;
	logic [WORD_W-1:0] rx_reg;
	logic [WORD_W-1:0] tx_reg;
	logic              dout_reg;
	logic              valid_reg;

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			pin_meta_reg  <= PIN_IDLE;
			pin_sync_reg  <= PIN_IDLE;
			sclk_last_reg <= 1'b1;
		end
		else
		begin
			pin_meta_reg  <= {spi_din, spi_sclk, spi_cs_n};
			pin_sync_reg  <= pin_meta_reg;
			sclk_last_reg <= pin_sync_reg[PIN_SCLK];
		end
	end

	assign cs_n_s    = pin_sync_reg[PIN_CS];
	assign sclk_rise = pin_sync_reg[PIN_SCLK] & ~sclk_last_reg;
	assign sclk_fall = ~pin_sync_reg[PIN_SCLK] & sclk_last_reg;

	// a frame cut short by chip select is dropped whole
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			state_reg <= IMUDT_IDLE;
		else
			unique case (state_reg)
				IMUDT_IDLE:
					if (!cs_n_s)
						state_reg <= IMUDT_SHIFT;
				IMUDT_SHIFT:
					if (cs_n_s)
						state_reg <= IMUDT_IDLE;
					else if (sclk_rise && cnt_reg == FRAME_LAST)
						state_reg <= IMUDT_HOLD;
				IMUDT_HOLD:
					if (cs_n_s)
						state_reg <= IMUDT_IDLE;
				default:
					state_reg <= IMUDT_IDLE;
			endcase
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			cnt_reg   <= '0;
			rx_reg    <= DATA_RST;
			valid_reg <= 1'b0;
		end
		else
		begin
			valid_reg <= state_reg == IMUDT_SHIFT && !cs_n_s
				&& sclk_rise && cnt_reg == FRAME_LAST;
			if (state_reg == IMUDT_IDLE)
				cnt_reg <= '0;
			else if (state_reg == IMUDT_SHIFT && sclk_rise)
			begin
				cnt_reg <= CNT_W'(cnt_reg + 1'b1);
				rx_reg  <= {rx_reg[WORD_W-2:0], pin_sync_reg[PIN_DIN]};
			end
		end
	end

	// reply of the previous frame goes out msb first on falling edges
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			tx_reg   <= DATA_RST;
			dout_reg <= 1'b0;
		end
		else if (state_reg == IMUDT_IDLE && !cs_n_s)
		begin
			tx_reg   <= fr.reply_word;
			dout_reg <= fr.reply_word[WORD_W-1];
		end
		else if (state_reg == IMUDT_SHIFT && sclk_fall)
		begin
			dout_reg <= tx_reg[WORD_W-1];
			tx_reg   <= {tx_reg[WORD_W-2:0], 1'b0};
		end
	end

	assign spi_dout       = dout_reg;
	assign fr.frame_valid = valid_reg;
	assign fr.frame_word  = rx_reg;

	sequence s_last_bit;
		state_reg == IMUDT_SHIFT && !cs_n_s && sclk_rise
			&& cnt_reg == FRAME_LAST;
	endsequence
	sequence s_one_pulse;
		fr.frame_valid ##1 !fr.frame_valid;
	endsequence
	property p_frame_pulse;
		@(posedge clk_sys) disable iff (reset)
		s_last_bit |=> s_one_pulse;
	endproperty
	a_frame_pulse: assert property (p_frame_pulse)
		else $error("frame pulse not one cycle after last bit");
endmodule : imudt_spi_engine

/* verification/imudt_spi_host.sv */
`timescale 1ns/1ps
module imudt_spi_host
	import imudt_pkg::*;
(
	// serial pins
	output logic      spi_cs_n,
	output logic      spi_sclk,
	output logic      spi_din,
	input  wire logic spi_dout
);
	// 300 ns half period keeps above the 5-clock minimum
	localparam time HALF = 300;

	initial
	begin
		spi_cs_n = 1'b1;
		spi_sclk = 1'b1;
		spi_din  = 1'b0;
	end

	// one frame, msb first; rx is the reply to the previous frame
	task automatic xfer(input logic [WORD_W-1:0] tx,
		output logic [WORD_W-1:0] rx);
		spi_cs_n = 1'b0;
		#HALF;
		for (int i = WORD_W - 1; i >= 0; i--)
		begin
			spi_sclk = 1'b0;
			spi_din  = tx[i];
			#HALF;
			spi_sclk = 1'b1;
			rx[i]    = spi_dout;
			#HALF;
		end
		spi_cs_n = 1'b1;
		// released line must not look like held data
		spi_din = ~spi_din;
		#(2 * HALF);
	endtask : xfer
endmodule : imudt_spi_host

/* verification/test_imudt_regs.sv */
`timescale 1ns/1ps
module test_imudt_regs;
	import imudt_pkg::*;
	logic                clk_sys;
	logic                reset;
	logic                spi_cs_n;
	logic                spi_sclk;
	logic                spi_din;
	logic                spi_dout;
	logic [FLAG_W-1:0]   selftest_fail;
	logic                sample_valid;
	logic [WORD_W-1:0]   temp_sample;
	logic [RATE_W-1:0]   rate_x_sample;
	logic [RATE_W-1:0]   rate_y_sample;
	logic [RATE_W-1:0]   rate_z_sample;
	logic                sensor_fail;
	logic [WORD_W-1:0]   page_select;
	logic [RATE_W-1:0]   rate_exp [AXES];
	int                  num_errors = 0;
	int                  n_tests = 0;

	imudt_regs uut (
		.clk_sys(clk_sys), .reset(reset), .spi_cs_n(spi_cs_n),
		.spi_sclk(spi_sclk), .spi_din(spi_din), .spi_dout(spi_dout),
		.selftest_fail(selftest_fail), .sample_valid(sample_valid),
		.temp_sample(temp_sample), .rate_x_sample(rate_x_sample),
		.rate_y_sample(rate_y_sample), .rate_z_sample(rate_z_sample),
		.sensor_fail(sensor_fail), .page_select(page_select)
	);
	imudt_spi_host host (
		.spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
		.spi_din(spi_din), .spi_dout(spi_dout)
	);

	initial
	begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : tick

	task automatic check16(input string nm, input logic [WORD_W-1:0] e,
		input logic [WORD_W-1:0] g);
		n_tests++;
		if (g !== e)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : check16

	// reply comes one frame later, so a second frame fetches it
	task automatic rd_chk(input logic [ADDR_W-1:0] a,
		input logic [WORD_W-1:0] e, input string nm);
		logic [WORD_W-1:0] r;
		host.xfer({1'b0, a, 8'h00}, r);
		host.xfer(16'h0000, r);
		check16(nm, e, r);
	endtask : rd_chk

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		logic [WORD_W-1:0] r;
		host.xfer({1'b1, a, d}, r);
	endtask : wr

	task automatic sample(input logic [WORD_W-1:0] t,
		input logic [RATE_W-1:0] x, input logic [RATE_W-1:0] y,
		input logic [RATE_W-1:0] z);
		temp_sample   = t;
		rate_x_sample = x;
		rate_y_sample = y;
		rate_z_sample = z;
		rate_exp      = '{x, y, z};
		sample_valid  = 1'b1;
		tick(1);
		sample_valid  = 1'b0;
		tick(2);
	endtask : sample

	task automatic test_reset;
		check16("sensor_fail", 16'h0000, {15'h0000, sensor_fail});
		check16("page_select", 16'h0000, page_select);
		rd_chk(ADDR_FLAGS, 16'h0000, "flags");
		$display("test reset done");
	endtask : test_reset

	task automatic test_flags;
		selftest_fail = 6'h2A;
		tick(4);
		selftest_fail = 6'h00;
		check16("sensor_fail", 16'h0001, {15'h0000, sensor_fail});
		rd_chk(ADDR_FLAGS, 16'h002A, "flags");
		rd_chk(ADDR_FLAGS, 16'h0000, "flags");
		rd_chk(ADDR_SYSERR, 16'h0020, "sys_err");
		check16("sensor_fail", 16'h0000, {15'h0000, sensor_fail});
		selftest_fail = 6'h15;
		tick(2);
		rd_chk(ADDR_FLAGS, 16'h0015, "flags");
		rd_chk(ADDR_FLAGS, 16'h0015, "flags");
		selftest_fail = 6'h00;
		rd_chk(ADDR_FLAGS, 16'h0015, "flags");
		rd_chk(ADDR_FLAGS, 16'h0000, "flags");
		$display("test flags done");
	endtask : test_flags

	task automatic test_words;
		sample(16'hEE3A, 32'h4E201234, 32'hFFFFFFFE, 32'hB1E0ABCD);
		rd_chk(ADDR_TEMP, 16'hEE3A, "temperature");
		for (int k = 0; k < AXES; k++)
		begin
			rd_chk(ADDR_RATE_HI[k], rate_exp[k][31:16], "rate_hi");
			rd_chk(ADDR_RATE_LO[k], rate_exp[k][15:0], "rate_lo");
		end
		sample(16'h1068, 32'h00000001, 32'h4E200000, 32'hFFFFFFFF);
		rd_chk(ADDR_RATE_LO[0], 16'h0001, "rate_lo");
		rd_chk(ADDR_RATE_HI[0], 16'h0000, "rate_hi");
		rd_chk(ADDR_RATE_HI[2], 16'hFFFF, "rate_hi");
		$display("test words done");
	endtask : test_words

	task automatic test_writes;
		wr(ADDR_RATE_HI[1], 8'h55);
		wr(ADDR_FLAGS, 8'h3F);
		wr(ADDR_TEMP + 7'h01, 8'hAA);
		rd_chk(ADDR_RATE_HI[1], 16'h4E20, "rate_hi");
		rd_chk(ADDR_FLAGS, 16'h0000, "flags");
		rd_chk(ADDR_TEMP, 16'h1068, "temperature");
		wr(ADDR_PAGE, 8'h01);
		check16("page_select", 16'h0001, page_select);
		rd_chk(ADDR_TEMP, 16'h0000, "temperature");
		wr(ADDR_PAGE + 7'h01, 8'h02);
		check16("page_select", 16'h0201, page_select);
		wr(ADDR_PAGE + 7'h01, 8'h00);
		check16("page_select", 16'h0001, page_select);
		wr(ADDR_PAGE, 8'h00);
		check16("page_select", 16'h0000, page_select);
		rd_chk(ADDR_TEMP, 16'h1068, "temperature");
		$display("test writes done");
	endtask : test_writes

	task automatic summarize;
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : summarize

	initial
	begin
		reset         = 1'b1;
		selftest_fail = 6'h00;
		sample_valid  = 1'b0;
		temp_sample   = 16'h0000;
		rate_x_sample = 32'h00000000;
		rate_y_sample = 32'h00000000;
		rate_z_sample = 32'h00000000;
		tick(5);
		reset = 1'b0;
		tick(5);
		test_reset();
		test_flags();
		test_words();
		test_writes();
		summarize();
	end

	// a hung run counts as a mismatch
	initial
	begin
		#2000000;
		num_errors++;
		summarize();
	end
endmodule : test_imudt_regs
